// File: ielpc_core.sv
// Purpose: Interrupt entry, return and wait/stop sequencing for an 8-bit CPU
// Assumes: Memory read data valid in the same cycle as mem_re_o
// Notes: CPU core reports each completed instruction with insn_done_i
//
// Overview of operation
// - Service recognized interrupts at instruction end
// - Push nine bytes, program counter first
// - Set global mask after flags stacked
// - Fetch highest-priority vector, jump there
// - Return pulls bytes reverse, restores masks
// - Reset sets gate and global mask bits
// - Gate bit software-clearable, set only by reset or non-maskable entry
// - Non-maskable pin beats all maskable sources
// - Maskable entry leaves gate bit alone
// - Unimplemented opcodes raise a trap
// - Trap stacks address of offending opcode
// - Software trap unmaskable, uninterruptible, sets mask
// - External request pin low-level by default
// - Enabled flag requests until flag cleared
// - Wait stacks, halts, leaves on interrupt
// - Wait keeps reading stacked flags address
// - Timer halts in wait only if allowed
// - Stop only when stop-disable bit clear
// - Stop left by pins or edge request
// - External pin wakes stop only unmasked
// - Non-maskable pin always wakes stop
// - Stop holds sequencer state and CPU/memory outputs; register port and pin sync stay live
// - Restart delay unless delay bit clear
// - Fixed vectors for pins and traps
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`default_nettype none
`include "ielpc_regs.svh"
module ielpc_core import ielpc_pkg::*; (
  // Clock, reset, power-on indication
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic por_i,
  // Request pins, active low
  input wire logic irq_b_i,
  input wire logic nonmaskable_request_pin_b_i,
  // Peripheral flags and local enables
  input wire logic [`IELPC_NPER-1:0] per_flag_i,
  input wire logic [`IELPC_NPER-1:0] per_en_i,
  // CPU core
  input wire logic insn_done_i,
  input wire ielpc_op_type op_i,
  input wire ielpc_cpu_type cpu_i,
  output logic cpu_hold_o,
  output logic pc_load_o,
  output logic [15:0] pc_o,
  output logic regs_load_o,
  output ielpc_cpu_type regs_o,
  output logic [7:0] flags_o,
  // Memory
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // Power control
  output logic clocks_run_o,
  output logic timer_halt_o,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  ielpc_state_type st, next_st;
  ielpc_cpu_type snap, next_snap, next_regs;
  logic [11:0] cnt, next_cnt;
  logic [15:0] vec, next_vec, sel_vec, next_pc, next_mem_addr;
  logic [7:0] flags, next_flags, next_mem_wdata;
  logic [2:0] ctrl, next_ctrl;
  logic [71:0] pbuf, next_pbuf;
  logic wai_q, next_wai, xt, next_xt, boot, next_boot, edge_pend;
  logic next_mem_we, next_mem_re, next_pc_load, next_regs_load;
  logic set_i, set_x, clr_edge, restore;
  logic irq_s1, irq_s2, irq_s3, nonmaskable_request_pin_s1, nonmaskable_request_pin_s2;
  logic [`IELPC_NPER-1:0] per_req;
  logic [31:0] rd_mux;

  wire [3:0] idx = cnt[3:0];
  wire [71:0] stk = {flags, snap.b, snap.a, snap.ix, snap.iy, snap.pc};
  wire irq_low = ~irq_s2;
  wire nonmaskable_request_pin_low = ~nonmaskable_request_pin_s2;
  wire irq_fall = irq_s3 & irq_low;
  wire irq_req = ctrl[`IELPC_C_EDGE] ? edge_pend : irq_low;
  wire nonmaskable_request_pin_req = nonmaskable_request_pin_low & ~flags[`IELPC_F_X];
  wire mask_req = ~flags[`IELPC_F_I] & (irq_req | (|per_req));
  wire any_int = nonmaskable_request_pin_req | mask_req;
  wire stop_exit = nonmaskable_request_pin_low | (~flags[`IELPC_F_I] & (irq_low | edge_pend));
  wire bus_req = avs_read_i | avs_write_i;
  wire wr_ok = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  wire wr_flags = wr_ok & (avs_address_i == `IELPC_OFS_FLAGS);
  wire wr_ctrl = wr_ok & (avs_address_i == `IELPC_OFS_CTRL);
  wire next_wait = ~(bus_req & avs_waitrequest_o);
  wire [7:0] pull_flags = pbuf[71:64];

  assign flags_o = flags;
  assign rd_mux = (avs_address_i == `IELPC_OFS_FLAGS) ? {24'h000000, flags} :
                  (avs_address_i == `IELPC_OFS_CTRL) ? {29'h00000000, ctrl} :
                  (avs_address_i == `IELPC_OFS_STAT) ? {23'h000000, any_int, st} :
                  32'h00000000;

  genvar g;
  generate
    for (g = 0; g < `IELPC_NPER; g++)
    begin : g_per
      assign per_req[g] = per_flag_i[g] & per_en_i[g];
    end
  endgenerate

  // Priority: non-maskable pin, external pin, then peripherals by index
  always_comb
  begin
    sel_vec = `IELPC_VEC_PER;
    for (int i = `IELPC_NPER - 1; i >= 0; i--)
    begin
      if (per_req[i])
        sel_vec = `IELPC_VEC_PER - 16'(2 * i);
    end
    if (irq_req)
      sel_vec = `IELPC_VEC_IRQ;
    if (nonmaskable_request_pin_req)
      sel_vec = `IELPC_VEC_NMI;
  end

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_vec = vec;
    next_snap = snap;
    next_wai = wai_q;
    next_xt = xt;
    next_boot = boot;
    next_pbuf = pbuf;
    next_mem_we = 1'b0;
    next_mem_re = 1'b0;
    next_mem_addr = mem_addr_o;
    next_mem_wdata = mem_wdata_o;
    next_pc = pc_o;
    next_pc_load = 1'b0;
    next_regs = regs_o;
    next_regs_load = 1'b0;
    set_i = 1'b0;
    set_x = 1'b0;
    clr_edge = 1'b0;
    restore = 1'b0;
    unique case (st)
      ST_BOOT:
      begin
        next_boot = 1'b1;
        next_cnt = 12'h000;
        next_vec = `IELPC_VEC_RESET;
        next_st = ST_VEC;
        if (por_i)
        begin
          next_cnt = `IELPC_RESTART_CYC - 12'h001;
          next_st = ST_DLY;
        end
      end
      ST_RUN:
      begin
        if (insn_done_i)
        begin
          next_snap = cpu_i;
          next_wai = 1'b0;
          next_xt = 1'b0;
          next_cnt = 12'h000;
          if (op_i.illegal)
          begin
            next_snap.pc = op_i.addr;
            next_vec = `IELPC_VEC_ILL;
            next_st = ST_PUSH;
          end
          else if (op_i.software_trap_instruction)
          begin
            next_vec = `IELPC_VEC_TRAP;
            next_st = ST_PUSH;
          end
          else if (op_i.wait_instruction)
          begin
            next_wai = 1'b1;
            next_st = ST_PUSH;
          end
          else if (op_i.stop)
          begin
            if (!flags[`IELPC_F_S])
              next_st = ST_STOP;
          end
          else if (op_i.rti)
            next_st = ST_PULL;
          else if (any_int)
          begin
            next_vec = sel_vec;
            next_xt = nonmaskable_request_pin_req;
            next_st = ST_PUSH;
          end
        end
      end
      ST_PUSH:
      begin
        next_mem_we = 1'b1;
        next_mem_addr = snap.sp - {12'h000, idx};
        next_mem_wdata = stk[{idx, 3'h0} +: 8];
        next_cnt = cnt + 12'h001;
        if (idx == `IELPC_LAST_BYTE)
        begin
          next_regs = snap;
          next_regs.sp = snap.sp - `IELPC_STACK_N;
          next_regs_load = 1'b1;
          next_cnt = 12'h000;
          next_st = ST_VEC;
          if (wai_q)
            next_st = ST_WAIT;
          else
          begin
            set_i = 1'b1;
            set_x = xt;
          end
        end
      end
      ST_WAIT:
      begin
        next_mem_re = 1'b1;
        next_mem_addr = snap.sp - 16'h0008;
        if (any_int)
        begin
          next_vec = sel_vec;
          set_i = 1'b1;
          set_x = nonmaskable_request_pin_req;
          next_cnt = 12'h000;
          next_st = ST_VEC;
        end
      end
      ST_STOP:
      begin
        if (stop_exit)
        begin
          next_boot = 1'b0;
          next_cnt = ctrl[`IELPC_C_RESTART] ? `IELPC_RESTART_CYC - 12'h001 : 12'h000;
          next_st = ST_DLY;
        end
      end
      ST_DLY:
      begin
        next_cnt = cnt - 12'h001;
        if (cnt == 12'h000)
        begin
          // Next state counts bytes from zero, so do not let the count wrap
          next_cnt = 12'h000;
          if (boot)
            next_st = ST_VEC;
          else
          begin
            next_snap = cpu_i;
            next_wai = 1'b0;
            next_xt = nonmaskable_request_pin_req;
            next_vec = sel_vec;
            next_st = any_int ? ST_PUSH : ST_RUN;
          end
        end
      end
      ST_VEC:
      begin
        next_cnt = cnt + 12'h001;
        next_mem_re = (idx != 4'h2);
        if (idx == 4'h0)
        begin
          next_mem_addr = vec;
          clr_edge = (vec == `IELPC_VEC_IRQ);
        end
        else if (idx == 4'h1)
        begin
          next_mem_addr = vec + 16'h0001;
          next_pbuf[7:0] = mem_rdata_i;
        end
        else
        begin
          next_pc = {pbuf[7:0], mem_rdata_i};
          next_pc_load = 1'b1;
          next_st = ST_RUN;
        end
      end
      ST_PULL:
      begin
        next_cnt = cnt + 12'h001;
        if (idx != 4'h9)
        begin
          next_mem_re = 1'b1;
          next_mem_addr = snap.sp + 16'h0001 + {12'h000, idx};
        end
        if (idx != 4'h0)
          next_pbuf[{4'h9 - idx, 3'h0} +: 8] = mem_rdata_i;
        if (idx == 4'h9)
        begin
          restore = 1'b1;
          next_regs = {pbuf[15:8], mem_rdata_i,
                       pbuf[31:16], pbuf[47:32], pbuf[55:48], pbuf[63:56],
                       snap.sp + `IELPC_STACK_N};
          next_regs_load = 1'b1;
          next_pc = {pbuf[15:8], mem_rdata_i};
          next_pc_load = 1'b1;
          next_st = ST_RUN;
        end
      end
    endcase
  end

  // Software write first, then return restore, then hardware sets win
  always_comb
  begin
    next_flags = flags;
    if (wr_flags)
      next_flags = {avs_writedata_i[7], avs_writedata_i[6] & flags[`IELPC_F_X],
                    avs_writedata_i[5:0]};
    if (restore)
      next_flags = {pull_flags[7], pull_flags[6] & flags[`IELPC_F_X], pull_flags[5:0]};
    if (set_i)
      next_flags[`IELPC_F_I] = 1'b1;
    if (set_x)
      next_flags[`IELPC_F_X] = 1'b1;
    next_ctrl = wr_ctrl ? avs_writedata_i[2:0] : ctrl;
  end

  // Pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {irq_s1, irq_s2, irq_s3} <= 3'h7;
      {nonmaskable_request_pin_s1, nonmaskable_request_pin_s2} <= 2'h3;
      edge_pend <= 1'b0;
    end
    else
    begin
      {irq_s1, irq_s2, irq_s3} <= {irq_b_i, irq_s1, irq_s2};
      {nonmaskable_request_pin_s1, nonmaskable_request_pin_s2} <= {nonmaskable_request_pin_b_i, nonmaskable_request_pin_s1};
      edge_pend <= ctrl[`IELPC_C_EDGE] & (irq_fall | (edge_pend & ~clr_edge));
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flags <= `IELPC_FLAGS_RST;
      ctrl <= `IELPC_CTRL_RST;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      flags <= next_flags;
      ctrl <= next_ctrl;
      avs_waitrequest_o <= next_wait;
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st <= ST_BOOT;
      cnt <= 12'h000;
      vec <= 16'h0000;
      snap <= '0;
      pbuf <= '0;
      {wai_q, xt, boot} <= 3'h1;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      vec <= next_vec;
      snap <= next_snap;
      pbuf <= next_pbuf;
      {wai_q, xt, boot} <= {next_wai, next_xt, next_boot};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {mem_we_o, mem_re_o, pc_load_o, regs_load_o} <= 4'h0;
      {mem_addr_o, pc_o} <= 32'h00000000;
      mem_wdata_o <= 8'h00;
      regs_o <= '0;
      {cpu_hold_o, clocks_run_o, timer_halt_o} <= 3'h6;
    end
    else
    begin
      {mem_we_o, mem_re_o} <= {next_mem_we, next_mem_re};
      {pc_load_o, regs_load_o} <= {next_pc_load, next_regs_load};
      {mem_addr_o, pc_o} <= {next_mem_addr, next_pc};
      mem_wdata_o <= next_mem_wdata;
      regs_o <= next_regs;
      cpu_hold_o <= (next_st != ST_RUN);
      clocks_run_o <= (next_st != ST_STOP);
      timer_halt_o <= (next_st == ST_WAIT) & next_flags[`IELPC_F_I] & ctrl[`IELPC_C_WDOG];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_push_first;
    st == ST_PUSH && idx == 4'h0 |=> mem_we_o && mem_addr_o == snap.sp;
  endproperty
  a_push_first: assert property (p_push_first) else $error("first push not at SP");

  property p_mask_set;
    st == ST_PUSH && idx == `IELPC_LAST_BYTE && !wai_q |=> flags[`IELPC_F_I] && st == ST_VEC;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("global mask not set");

  property p_gate_kept;
    st == ST_PUSH && idx == `IELPC_LAST_BYTE && !xt && !wr_flags |=>
      flags[`IELPC_F_X] == $past(flags[`IELPC_F_X]);
  endproperty
  a_gate_kept: assert property (p_gate_kept) else $error("gate bit changed");

  property p_gate_oneway;
    !flags[`IELPC_F_X] && !set_x |=> !flags[`IELPC_F_X];
  endproperty
  a_gate_oneway: assert property (p_gate_oneway) else $error("gate bit set by software");

  property p_stop_nop;
    st == ST_RUN && insn_done_i && op_i.stop && !op_i.illegal && !op_i.software_trap_instruction && !op_i.wait_instruction &&
      flags[`IELPC_F_S] |=> st == ST_RUN ##1 clocks_run_o;
  endproperty
  a_stop_nop: assert property (p_stop_nop) else $error("stop taken while disabled");

  property p_wait_read;
    st == ST_WAIT |=> mem_re_o && !mem_we_o && mem_addr_o == snap.sp - 16'h0008;
  endproperty
  a_wait_read: assert property (p_wait_read) else $error("wait read address wrong");

  property p_timer;
    st == ST_WAIT && !any_int && $stable(flags) |=>
      timer_halt_o == (flags[`IELPC_F_I] & ctrl[`IELPC_C_WDOG]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer halt wrong in wait");

  property p_stop_hold;
    st == ST_STOP && !stop_exit |=> $stable(pc_o) && !mem_we_o && !mem_re_o && !clocks_run_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("state moved during stop");

  property p_nonmaskable_request_pin_first;
    st == ST_RUN && insn_done_i && nonmaskable_request_pin_req && !(|op_i[20:16]) |=> vec == `IELPC_VEC_NMI;
  endproperty
  a_nonmaskable_request_pin_first: assert property (p_nonmaskable_request_pin_first) else $error("pin lost priority");
endmodule
`default_nettype wire

// File: ielpc_core_test.sv
// Purpose: Self-checking bench for interrupt entry, traps, wait and stop
// Assumes: One wait cycle on the register bus, registered core outputs
// Notes: Outputs are read right after an edge, before that edge's updates land
`default_nettype none
`include "ielpc_regs.svh"
module ielpc_core_test import ielpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, por, insn_done, irq_b, nonmaskable_request_pin_b, avs_read, avs_write;
  logic [14:0] per_flag, per_en;
  ielpc_op_type op;
  ielpc_cpu_type cpu, regs;
  logic cpu_hold, pc_load, regs_load, mem_we, mem_re, clocks_run, timer_halt, avs_wait;
  logic [15:0] pc_new, mem_addr;
  logic [7:0] flags, mem_wdata, mem_rdata, q;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] wa [16];
  logic [7:0] wd [16];
  logic [15:0] pc;
  int nw, cyc, err_total, checked;

  ielpc_core u_ielpc_core (.clk_i(clk), .rst_b_i(rst_b), .por_i(por), .irq_b_i(irq_b),
    .nonmaskable_request_pin_b_i(nonmaskable_request_pin_b), .per_flag_i(per_flag), .per_en_i(per_en), .insn_done_i(insn_done),
    .op_i(op), .cpu_i(cpu), .cpu_hold_o(cpu_hold), .pc_load_o(pc_load), .pc_o(pc_new),
    .regs_load_o(regs_load), .regs_o(regs), .flags_o(flags), .mem_we_o(mem_we),
    .mem_re_o(mem_re), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .clocks_run_o(clocks_run), .timer_halt_o(timer_halt),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wait));

  ielpc_far_model u_ielpc_far_model (.clk_i(clk), .mem_addr_i(mem_addr),
    .mem_rdata_o(mem_rdata), .irq_b_o(irq_b), .nonmaskable_request_pin_b_o(nonmaskable_request_pin_b),
    .per_flag_o(per_flag), .per_en_o(per_en));

  function automatic logic [15:0] vec(input logic [15:0] v);
    return {4'h5, v[3:0], 4'h5, v[3:0] + 4'h1};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clk);
    while (avs_wait !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(n < 50), 16'h0001);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Kind bits: illegal, trap, wait, stop, return
  task automatic issue(input logic [4:0] kind, input logic [15:0] a);
    @(posedge clk);
    insn_done <= 1'b1;
    op <= {kind, a};
    @(posedge clk);
    insn_done <= 1'b0;
    op <= '0;
  endtask

  // Records stack writes until the new program counter is handed over
  task automatic collect();
    nw = 0;
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
      if (mem_we === 1'b1 && nw < 16)
      begin
        wa[nw] = mem_addr;
        wd[nw] = mem_wdata;
        nw++;
      end
    end while (pc_load !== 1'b1 && cyc < 6000);
    chk(16'(cyc < 6000), 16'h0001);
    pc = pc_new;
  endtask

  task automatic t_reset();
    collect();
    chk(pc, vec(`IELPC_VEC_RESET));
    chk(16'(flags), 16'h00D0);
    av(1'b1, `IELPC_OFS_FLAGS, 8'h00);
    av(1'b1, `IELPC_OFS_FLAGS, 8'h40);
    av(1'b0, `IELPC_OFS_FLAGS, 8'h00);
    chk(16'(q), 16'h0000);
  endtask

  task automatic t_entry();
    logic [71:0] e;
    e = {cpu.pc[7:0], cpu.pc[15:8], cpu.iy[7:0], cpu.iy[15:8], cpu.ix[7:0], cpu.ix[15:8],
      cpu.a, cpu.b, 8'h00};
    u_ielpc_far_model.pins(1'b1, 1'b1, 15'h0004);
    issue(5'b00000, 16'h1000);
    collect();
    chk(16'(nw), 16'h0009);
    for (int k = 0; k < 9; k++)
    begin
      chk(wa[k], 16'(cpu.sp - k));
      chk(16'(wd[k]), 16'(e[71 - 8 * k -: 8]));
    end
    chk(pc, vec(16'hFFEC));
    chk(16'(flags), 16'h0010);
    av(1'b1, `IELPC_OFS_FLAGS, 8'h00);
    u_ielpc_far_model.pins(1'b1, 1'b0, 15'h0004);
    repeat (3) @(posedge clk);
    issue(5'b00000, 16'h1000);
    collect();
    chk(pc, vec(`IELPC_VEC_NMI));
    chk(16'(flags), 16'h0050);
    u_ielpc_far_model.pins(1'b1, 1'b1, 15'h0000);
  endtask

  task automatic t_traps();
    issue(5'b10000, 16'h2222);
    collect();
    chk({wd[1], wd[0]}, 16'h2222);
    chk(pc, vec(`IELPC_VEC_ILL));
    av(1'b1, `IELPC_OFS_FLAGS, 8'h00);
    issue(5'b01000, 16'h3000);
    collect();
    chk(pc, vec(`IELPC_VEC_TRAP));
    chk(16'(flags[4]), 16'h0001);
  endtask

  task automatic t_wait();
    av(1'b1, `IELPC_OFS_FLAGS, 8'h00);
    av(1'b1, `IELPC_OFS_CTRL, 8'h03);
    issue(5'b00100, 16'h4000);
    repeat (30) @(posedge clk);
    chk(16'(mem_re), 16'h0001);
    chk(mem_addr, 16'(cpu.sp - 8));
    chk(16'(timer_halt), 16'h0000);
    chk(16'(cpu_hold), 16'h0001);
    u_ielpc_far_model.pins(1'b0, 1'b1, 15'h0000);
    collect();
    chk(pc, vec(`IELPC_VEC_IRQ));
    u_ielpc_far_model.pins(1'b1, 1'b1, 15'h0000);
  endtask

  task automatic t_stop();
    av(1'b1, `IELPC_OFS_FLAGS, 8'h80);
    issue(5'b00010, 16'h5000);
    repeat (5) @(posedge clk);
    chk(16'(clocks_run), 16'h0001);
    av(1'b1, `IELPC_OFS_FLAGS, 8'h10);
    issue(5'b00010, 16'h5000);
    u_ielpc_far_model.pins(1'b0, 1'b1, 15'h0000);
    repeat (20) @(posedge clk);
    chk(16'(clocks_run), 16'h0000);
    u_ielpc_far_model.pins(1'b0, 1'b0, 15'h0000);
    collect();
    chk(pc, vec(`IELPC_VEC_NMI));
    chk(16'(cyc >= 4064), 16'h0001);
    u_ielpc_far_model.pins(1'b1, 1'b1, 15'h0000);
  endtask

  // Return pulls flags, B, A, X, Y, PC from SP+1 upwards
  task automatic t_return();
    issue(5'b00001, 16'h6000);
    collect();
    chk(pc, 16'h5758);
    chk(regs.ix, 16'h5354);
    chk(16'(flags), 16'h0050);
  endtask

  // A one-cycle pulse only counts in edge mode
  task automatic t_edge();
    av(1'b1, `IELPC_OFS_FLAGS, 8'h00);
    av(1'b1, `IELPC_OFS_CTRL, 8'h07);
    u_ielpc_far_model.pins(1'b0, 1'b1, 15'h0000);
    u_ielpc_far_model.pins(1'b1, 1'b1, 15'h0000);
    repeat (4) @(posedge clk);
    issue(5'b00000, 16'h7000);
    collect();
    chk(pc, vec(`IELPC_VEC_IRQ));
  endtask

  // Power-on reset in mid-run waits out the restart delay
  task automatic t_por();
    @(posedge clk);
    rst_b <= 1'b0;
    por <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    collect();
    chk(pc, vec(`IELPC_VEC_RESET));
    chk(16'(cyc >= 4064), 16'h0001);
    chk(16'(flags), 16'h00D0);
    por <= 1'b0;
  endtask

  task automatic finish_test();
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #3000000;
    err_total++;
    finish_test();
  end

  initial
  begin
    rst_b = 1'b0;
    por = 1'b0;
    insn_done = 1'b0;
    op = '0;
    cpu = {16'h1234, 16'h5678, 16'h9ABC, 8'hDE, 8'hF0, 16'h01FF};
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_entry();
    t_traps();
    t_wait();
    t_stop();
    t_return();
    t_edge();
    t_por();
    finish_test();
  end
endmodule
`default_nettype wire

// File: ielpc_far_model.sv
// Purpose: Far side of the sequencer: request pins, peripheral flags, memory
// Assumes: Memory answers in the same cycle as the address
// Notes: Every memory byte reads as {4'h5, address low nibble}
`default_nettype none
`include "ielpc_regs.svh"
module ielpc_far_model (
  // Clock
  input wire logic clk_i,
  // Memory
  input wire logic [15:0] mem_addr_i,
  output logic [7:0] mem_rdata_o,
  // Requests
  output var logic irq_b_o,
  output var logic nonmaskable_request_pin_b_o,
  output var logic [`IELPC_NPER-1:0] per_flag_o,
  output var logic [`IELPC_NPER-1:0] per_en_o
);
  timeunit 1ns;
  timeprecision 1ns;

  assign mem_rdata_o = {4'h5, mem_addr_i[3:0]};

  initial
  begin
    irq_b_o = 1'b1;
    nonmaskable_request_pin_b_o = 1'b1;
    per_flag_o = '0;
    per_en_o = '1;
  end

  // Pins change just after an edge, like any synchronous source
  task automatic pins(input logic irq_b, input logic nonmaskable_request_pin_b, input logic [14:0] flag);
    @(posedge clk_i);
    irq_b_o <= irq_b;
    nonmaskable_request_pin_b_o <= nonmaskable_request_pin_b;
    per_flag_o <= flag;
  endtask
endmodule
`default_nettype wire

// File: ielpc_pkg.sv
// Purpose: Types shared by the exception and low-power sequencer
// Assumes: One-hot state codes
// Notes: Struct fields are packed most significant first
`default_nettype none
package ielpc_pkg;
  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_RUN = 8'h02,
    ST_PUSH = 8'h04,
    ST_WAIT = 8'h08,
    ST_STOP = 8'h10,
    ST_DLY = 8'h20,
    ST_VEC = 8'h40,
    ST_PULL = 8'h80
  } ielpc_state_type;
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] iy;
    logic [15:0] ix;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] sp;
  } ielpc_cpu_type;
  typedef struct packed {
    logic illegal;
    logic software_trap_instruction;
    logic wait_instruction;
    logic stop;
    logic rti;
    logic [15:0] addr;
  } ielpc_op_type;
endpackage
`default_nettype wire

// File: ielpc_regs.svh
// Purpose: Offsets, field positions, reset values and counts for ielpc_core
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Only the low byte of each register word is used, plus bit 8 of the status word
`ifndef IELPC_REGS_SVH
`define IELPC_REGS_SVH
`define IELPC_OFS_FLAGS 4'h0
`define IELPC_OFS_CTRL 4'h4
`define IELPC_OFS_STAT 4'h8
`define IELPC_F_S 7
`define IELPC_F_X 6
`define IELPC_F_I 4
`define IELPC_C_RESTART 0
`define IELPC_C_WDOG 1
`define IELPC_C_EDGE 2
`define IELPC_FLAGS_RST 8'hD0
`define IELPC_CTRL_RST 3'h1
`define IELPC_VEC_RESET 16'hFFFE
`define IELPC_VEC_ILL 16'hFFF8
`define IELPC_VEC_TRAP 16'hFFF6
`define IELPC_VEC_NMI 16'hFFF4
`define IELPC_VEC_IRQ 16'hFFF2
`define IELPC_VEC_PER 16'hFFF0
`define IELPC_NPER 15
`define IELPC_LAST_BYTE 4'h8
`define IELPC_STACK_N 16'h0009
`define IELPC_RESTART_CYC 12'hFE0
`endif
